/* File: logic/adc_pkg.sv */
// adc_pkg: register map, field positions, defaults and timing constants
// for the stereo converter control register bank.
// assumes: a host-side control-port decoder delivers byte writes and reads.
package adc_pkg;
  localparam logic [3:0] ADDR_POWER = 4'h1;
  localparam logic [3:0] ADDR_LEFT_ANALOG = 4'h2;
  localparam logic [3:0] ADDR_RIGHT_ANALOG = 4'h3;
  localparam logic [3:0] ADDR_LEFT_DIGITAL = 4'h4;
  localparam logic [3:0] ADDR_RIGHT_DIGITAL = 4'h5;
  localparam logic [3:0] ADDR_TONE = 4'h6;
  localparam logic [3:0] ADDR_MODE = 4'h7;
  localparam logic [3:0] ADDR_ATTACK = 4'h8;

  localparam logic [7:0] RST_POWER = 8'hd2;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_ATTACK = 8'h10;
  localparam logic [7:0] POWER_RW_MASK = 8'hf3;

  // power register fields
  localparam int P_AUTOMUTE = 7;
  localparam int P_MODE_HI = 6;
  localparam int P_MODE_LO = 5;
  localparam int P_POP = 4;
  localparam int P_LOWPWR = 1;
  localparam int P_PORTEN = 0;
  // mode register fields
  localparam int M_LOW_HI = 7;
  localparam int M_LOW_LO = 6;
  localparam int M_HIGH_HI = 5;
  localparam int M_HIGH_LO = 4;
  localparam int M_LINK = 3;
  localparam int M_EMPH_HI = 2;
  localparam int M_EMPH_LO = 1;
  localparam int M_BYPASS = 0;

  localparam logic [1:0] TR_IMMEDIATE = 2'h0;
  localparam logic [1:0] TR_ZEROCROSS = 2'h1;
  localparam logic [1:0] TR_RAMPED = 2'h2;

  localparam logic [3:0] SHELF_MAX = 4'hc;
  localparam logic [4:0] ANALOG_MAX_DB = 5'h19;
  localparam logic signed [7:0] DIGITAL_MIN_DB = -8'sd96;
  localparam logic [9:0] ZC_TIMEOUT = 10'h200;
  localparam logic [5:0] ATTACK_NUM = 6'h20;
  localparam logic [7:0] POP_TOP = 8'hff;
  localparam logic [3:0] POP_SAMPLES = 4'h4;

  typedef enum logic [3:0] {
    PW_OFF = 4'b0001,
    PW_UP = 4'b0010,
    PW_ON = 4'b0100,
    PW_DOWN = 4'b1000
  } adc_pwr_t;

  typedef enum logic [1:0] {
    ZC_IDLE = 2'b01,
    ZC_WAIT = 2'b10
  } adc_zc_t;

  typedef struct packed {
    logic mute;
    logic signed [10:0] gain_eighths;
    logic [4:0] analog_db;
  } adc_chan_t;

  typedef struct packed {
    logic [3:0] low_level;
    logic [3:0] high_level;
    logic [1:0] low_corner;
    logic [1:0] high_corner;
    logic high_active;
    logic [1:0] emphasis;
    logic bypass;
    logic automute;
  } adc_tone_t;
endpackage : adc_pkg

/* File: logic/adc_regs.sv */
// adc_regs: control register bank with level transitions, power/pop
// sequencing and the limiter attack-rate step generator.
// assumes: reg_* come from the control-port decoder in this clock domain;
// frame_tick_i pulses once per sample_frame_clock period.
// Function
// - pop suppression ramps quiescent level slowly during power-on and power-off.
// - low-power state while power-down set; register contents always retained.
// - power-down resets set; normal operation waits until host clears it.
// - setting port enable activates port and restores all settings to defaults.
// - analog attenuation is two's complement, 1 dB steps, 0 to -25 dB.
// - positive analog attenuation values behave exactly like zero.
// - level changes follow the selected soft-ramp / zero-cross mode.
// - digital gain is two's complement, 1 dB steps, +18 to -96 dB; positive codes are passed on unclamped, up to +127 dB.
// - digital gain below -96 dB mutes that channel.
// - shelf levels are unsigned 0..12 dB; codes above 12 clamp to 12.
// - treble boost and its corner have no effect in double speed.
// - bass corner codes 00/01/10 give 50/100/200 Hz; 11 reserved.
// - treble corner codes 00/01/10 give 2/4/7 kHz; 11 reserved.
// - link bit makes both outputs use channel A attenuation and gain.
// - emphasis field selects none, 44.1, 48 or 32 kHz filter.
// - emphasis is never applied in double speed mode.
// - bypass skips gain, mute, tone, limiter and mixing; analog stays.
// - attack rate is 32 over register value, frames per 1/8 dB step.
// - transition modes immediate, zero-cross, ramped; 512-sample zero-cross timeout.
`timescale 1ns/10ps
module adc_regs
  import adc_pkg::*;
(
  input wire logic clk_i, // 250 MHz clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  input wire logic [3:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // write data
  output logic [7:0] reg_rdata_o, // read data, one cycle after read
  input wire logic frame_tick_i, // one pulse per sample frame
  input wire logic [1:0] zero_cross_i, // per-channel signal zero crossing
  input wire logic double_speed_i, // converter runs double speed
  input wire logic limiter_enable_i, // limiter enable from mixing register
  input wire logic limiter_clip_i, // limiter wants more attenuation
  output adc_chan_t headphone_out_left_o, // applied left settings
  output adc_chan_t headphone_out_right_o, // applied right settings
  output adc_tone_t tone_o, // effective tone and filter settings
  output logic low_power_o, // device held in low-power state
  output logic host_port_active_o, // control port enabled
  output logic [7:0] quiescent_level_o, // output quiescent bias level
  output logic [2:0] attack_steps_o // 1/8 dB attack steps this frame
);
  logic [7:0] power_q, power_d;
  logic [7:0] level_q [8], level_d [8];
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] wr_val;
  logic port_on;

  function automatic logic [4:0] analog_db(input logic [7:0] code);
    logic [7:0] mag;
    mag = 8'h00 - code;
    if (!code[7]) analog_db = 5'h00;
    else if (mag > {3'h0, ANALOG_MAX_DB}) analog_db = ANALOG_MAX_DB;
    else analog_db = mag[4:0];
  endfunction : analog_db

  function automatic logic [3:0] shelf(input logic [3:0] code);
    shelf = (code > SHELF_MAX) ? SHELF_MAX : code;
  endfunction : shelf

  // register file, indexed by address 2..8; power register kept apart
  assign port_on = power_q[P_PORTEN];
  assign wr_val = reg_wdata_i;
  always_comb begin
    power_d = power_q;
    level_d = level_q;
    if (reg_wr_i && reg_addr_i == ADDR_POWER) begin
      if (wr_val[P_PORTEN] && !port_on) begin
        // enabling the port restores defaults but leaves it enabled
        power_d = RST_POWER | 8'h01;
        for (int i = 0; i < 8; i++) begin
          level_d[i] = (i == int'(ADDR_ATTACK[2:0])) ?
              RST_ATTACK : RST_LEVEL;
        end
      end else begin
        power_d = wr_val & POWER_RW_MASK;
      end
    end else if (reg_wr_i && reg_addr_i >= ADDR_LEFT_ANALOG &&
                 reg_addr_i <= ADDR_ATTACK) begin
      level_d[reg_addr_i[2:0]] = wr_val;
    end
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_POWER) rdata_d = power_q;
      else if (reg_addr_i >= ADDR_LEFT_ANALOG && reg_addr_i <= ADDR_ATTACK)
        rdata_d = level_q[reg_addr_i[2:0]];
      else rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      power_q <= RST_POWER;
      for (int i = 0; i < 8; i++) begin
        level_q[i] <= (i == int'(ADDR_ATTACK[2:0])) ? RST_ATTACK : RST_LEVEL;
      end
      rdata_q <= 8'h00;
    end else begin
      power_q <= power_d;
      level_q <= level_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign host_port_active_o = port_on;

  // power sequencing with optional slow bias ramp
  adc_pwr_t pwr_q, pwr_d;
  logic [7:0] bias_q, bias_d;
  logic [3:0] pop_cnt_q, pop_cnt_d;
  logic low_power_request, pop_en, pop_step;
  assign low_power_request = power_q[P_LOWPWR];
  assign pop_en = power_q[P_POP];
  assign pop_step = frame_tick_i && (pop_cnt_q == POP_SAMPLES - 4'h1);
  always_comb begin
    pwr_d = pwr_q;
    bias_d = bias_q;
    pop_cnt_d = pop_cnt_q;
    if (frame_tick_i) begin
      pop_cnt_d = pop_step ? 4'h0 : pop_cnt_q + 4'h1;
    end
    unique case (pwr_q)
      PW_OFF: if (!low_power_request) pwr_d = PW_UP;
      PW_UP: begin
        if (low_power_request) pwr_d = PW_DOWN;
        else if (!pop_en || bias_q == POP_TOP) begin
          bias_d = POP_TOP;
          pwr_d = PW_ON;
        end else if (pop_step) bias_d = bias_q + 8'h01;
      end
      PW_ON: if (low_power_request) pwr_d = PW_DOWN;
      PW_DOWN: begin
        if (!low_power_request) pwr_d = PW_UP;
        else if (!pop_en || bias_q == 8'h00) begin
          bias_d = 8'h00;
          pwr_d = PW_OFF;
        end else if (pop_step) bias_d = bias_q - 8'h01;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwr_q <= PW_OFF;
      bias_q <= 8'h00;
      pop_cnt_q <= 4'h0;
    end else begin
      pwr_q <= pwr_d;
      bias_q <= bias_d;
      pop_cnt_q <= pop_cnt_d;
    end
  end

  assign low_power_o = low_power_request || (pwr_q == PW_OFF);
  assign quiescent_level_o = bias_q;

  // per-channel level transitions
  logic link, bypass;
  logic [1:0] tmode;
  assign link = level_q[ADDR_MODE[2:0]][M_LINK];
  assign bypass = level_q[ADDR_MODE[2:0]][M_BYPASS];
  // ramping is not offered at double speed, so it falls back to zero-cross
  always_comb begin
    tmode = {power_q[P_MODE_HI], power_q[P_MODE_LO]};
    if (double_speed_i && tmode == TR_RAMPED) tmode = TR_ZEROCROSS;
  end

  adc_chan_t chan_q [2];
  for (genvar c = 0; c < 2; c++) begin : g_chan
    adc_zc_t zc_q, zc_d;
    logic [9:0] to_q, to_d;
    adc_chan_t cur_q, cur_d, tgt;
    logic [7:0] ana_code, dig_code;
    logic fire;
    assign ana_code = level_q[(link ? 0 : c) + 2];
    assign dig_code = level_q[(link ? 0 : c) + 4];
    always_comb begin
      tgt.analog_db = analog_db(ana_code);
      tgt.mute = !bypass && ($signed(dig_code) < DIGITAL_MIN_DB);
      tgt.gain_eighths = bypass ? 11'sd0 :
          11'($signed({{3{dig_code[7]}}, dig_code}) <<< 3);
      fire = zero_cross_i[c] || (frame_tick_i && to_q == ZC_TIMEOUT - 10'h1);
      cur_d = cur_q;
      zc_d = zc_q;
      to_d = to_q;
      unique case (zc_q)
        ZC_IDLE: begin
          to_d = 10'h0;
          if (tmode == TR_IMMEDIATE || tmode == 2'h3) begin
            cur_d = tgt;
          end else if (tmode == TR_RAMPED) begin
            cur_d.mute = tgt.mute;
            if (frame_tick_i && cur_q.gain_eighths < tgt.gain_eighths)
              cur_d.gain_eighths = cur_q.gain_eighths + 11'sd1;
            else if (frame_tick_i && cur_q.gain_eighths > tgt.gain_eighths)
              cur_d.gain_eighths = cur_q.gain_eighths - 11'sd1;
            if (cur_q.analog_db != tgt.analog_db) zc_d = ZC_WAIT;
          end else if (cur_q != tgt) begin
            zc_d = ZC_WAIT;
          end
        end
        ZC_WAIT: begin
          if (frame_tick_i) to_d = to_q + 10'h1;
          if (fire) begin
            zc_d = ZC_IDLE;
            if (tmode == TR_RAMPED) begin
              // analog moves one dB per crossing while ramping
              if (cur_q.analog_db < tgt.analog_db)
                cur_d.analog_db = cur_q.analog_db + 5'h1;
              else if (cur_q.analog_db > tgt.analog_db)
                cur_d.analog_db = cur_q.analog_db - 5'h1;
            end else begin
              cur_d = tgt;
            end
          end
        end
        default: zc_d = ZC_IDLE;
      endcase
    end
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        zc_q <= ZC_IDLE;
        to_q <= 10'h0;
        cur_q <= '0;
      end else begin
        zc_q <= zc_d;
        to_q <= to_d;
        cur_q <= cur_d;
      end
    end
    assign chan_q[c] = cur_q;
  end

  assign headphone_out_left_o = chan_q[0];
  assign headphone_out_right_o = chan_q[1];

  // effective tone and filter selections, registered
  adc_tone_t tone_q, tone_d;
  logic [7:0] tone_reg, mode_reg;
  assign tone_reg = level_q[ADDR_TONE[2:0]];
  assign mode_reg = level_q[ADDR_MODE[2:0]];
  always_comb begin
    tone_d.bypass = bypass;
    tone_d.automute = power_q[P_AUTOMUTE] && !bypass;
    tone_d.low_level = bypass ? 4'h0 : shelf(tone_reg[7:4]);
    tone_d.high_level = (bypass || double_speed_i) ? 4'h0 :
        shelf(tone_reg[3:0]);
    tone_d.low_corner = {mode_reg[M_LOW_HI], mode_reg[M_LOW_LO]};
    tone_d.high_corner = {mode_reg[M_HIGH_HI], mode_reg[M_HIGH_LO]};
    tone_d.high_active = !double_speed_i && !bypass;
    tone_d.emphasis = double_speed_i ? 2'h0 :
        {mode_reg[M_EMPH_HI], mode_reg[M_EMPH_LO]};
  end

  // attack: add the rate value each frame, one step per 32 accumulated
  logic [8:0] acc_q, acc_d, acc_sum;
  logic [2:0] steps_q, steps_d;
  logic lim_run;
  assign lim_run = limiter_enable_i && limiter_clip_i && !bypass;
  always_comb begin
    acc_sum = {4'h0, acc_q[4:0]} + {1'b0, level_q[ADDR_ATTACK[2:0]]};
    acc_d = acc_q;
    steps_d = 3'h0;
    if (!lim_run) begin
      acc_d = 9'h0;
    end else if (frame_tick_i) begin
      steps_d = acc_sum[7:5];
      acc_d = {4'h0, acc_sum[4:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tone_q <= '0;
      acc_q <= 9'h0;
      steps_q <= 3'h0;
    end else begin
      tone_q <= tone_d;
      acc_q <= acc_d;
      steps_q <= steps_d;
    end
  end

  assign tone_o = tone_q;
  assign attack_steps_o = steps_q;
endmodule : adc_regs

/* File: tb/adc_host.sv */
// adc_host: host side of the register port, one byte per transfer.
// assumes: the bench calls xfer; one clock domain.
`timescale 1ns/10ps
module adc_host
  import adc_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic [7:0] rdata_i, // read data
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output logic [3:0] addr_o, // address
  output logic [7:0] wdata_o // write data
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 4'h0;
    wdata_o = 8'h00;
  end
  // idle bus shows the inverse of the last value, never a stale copy
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = (w && a == ADDR_ATTACK && d == 8'h00) ? 8'h01 : d;
    @(posedge clk_i);
    #1;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask : xfer
endmodule : adc_host

/* File: tb/adc_regs_asserts.sv */
// adc_regs_asserts: port checks on the control register bank.
// assumes: bound to adc_regs; one clock domain.
`timescale 1ns/10ps
module adc_regs_asserts
  import adc_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [3:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic [7:0] reg_rdata_o, // read data
  input wire logic frame_tick_i, // frame pulse
  input wire logic double_speed_i, // double speed
  input wire logic limiter_enable_i, // limiter enable
  input wire adc_tone_t tone_o, // tone settings
  input wire logic low_power_o, // low power
  input wire logic host_port_active_o, // port active
  input wire logic [2:0] attack_steps_o // attack steps
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic prd;
  assign prd = reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_POWER;
  property p_res; prd |=> reg_rdata_o[3:2] == 2'b00;
  endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_pdn; prd |=> !reg_rdata_o[P_LOWPWR] || low_power_o;
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down not low power");
  property p_port; prd |=> reg_rdata_o[P_PORTEN] == host_port_active_o;
  endproperty
  a_port: assert property (p_port) else $error("port flag differs");
  property p_keep; reg_wr_i && reg_addr_i == ADDR_LEFT_ANALOG ##2 reg_rd_i
    && reg_addr_i == ADDR_LEFT_ANALOG |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  a_keep: assert property (p_keep) else $error("value not kept");
  property p_idle; !frame_tick_i |=> attack_steps_o == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("steps off tick");
  property p_off; frame_tick_i && !limiter_enable_i |=> attack_steps_o == 3'h0;
  endproperty
  a_off: assert property (p_off) else $error("steps while off");
  property p_treb; double_speed_i [*2] |-> tone_o.high_level == 4'h0;
  endproperty
  a_treb: assert property (p_treb) else $error("treble in double speed");
  property p_emph; double_speed_i [*2] |-> tone_o.emphasis == 2'h0;
  endproperty
  a_emph: assert property (p_emph) else $error("emphasis in double speed");
endmodule : adc_regs_asserts
bind adc_regs adc_regs_asserts u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .frame_tick_i(frame_tick_i), .double_speed_i(double_speed_i),
  .limiter_enable_i(limiter_enable_i), .tone_o(tone_o),
  .low_power_o(low_power_o), .host_port_active_o(host_port_active_o),
  .attack_steps_o(attack_steps_o));

/* File: tb/tb_audio_dac_control_registers.sv */
// tb_audio_dac_control_registers: self-checking bench for adc_regs.
// assumes: adc_host drives the register port; frame ticks every 4 clocks.
`timescale 1ns/10ps
module tb_audio_dac_control_registers;
  import adc_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic frame_tick_i = 1'b0;
  logic [1:0] zero_cross_i = 2'h0;
  logic double_speed_i = 1'b0;
  logic limiter_enable = 1'b0;
  logic lim_clip = 1'b0;
  logic reg_wr_i, reg_rd_i, low_power_o, port_act;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, q, bias;
  logic [2:0] steps_o;
  adc_chan_t hl, hr;
  adc_tone_t tone;
  int errors = 0, num_checks = 0, ticks = 0, steps = 0, ph = 0, n;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (frame_tick_i && limiter_enable && lim_clip) ticks++;
    steps += int'(steps_o);
    #1;
    ph++;
    frame_tick_i = (ph % 4 == 0);
  end
  adc_host u_host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  adc_regs DUT (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .frame_tick_i(frame_tick_i),
    .zero_cross_i(zero_cross_i), .double_speed_i(double_speed_i),
    .limiter_enable_i(limiter_enable), .limiter_clip_i(lim_clip),
    .headphone_out_left_o(hl), .headphone_out_right_o(hr), .tone_o(tone),
    .low_power_o(low_power_o), .host_port_active_o(port_act),
    .quiescent_level_o(bias), .attack_steps_o(steps_o));
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_reg
  task automatic cmp_out(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_out
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00, q);
    cmp_reg(q, e);
  endtask : rd
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic t_reset;
    rd(ADDR_POWER, RST_POWER);
    for (int a = 2; a < 8; a++) rd(4'(a), RST_LEVEL);
    rd(ADDR_ATTACK, RST_ATTACK);
    rd(4'h9, 8'h00);
    cmp_reg({bias[7:1], low_power_o}, 8'h01);
    cmp_out(16'(port_act), 16'h0000);
    wr(ADDR_LEFT_ANALOG, 8'hf6);
    wr(ADDR_POWER, 8'h01);
    rd(ADDR_POWER, 8'hd3);
    rd(ADDR_LEFT_ANALOG, 8'h00);
    cmp_out(16'(port_act), 16'h0001);
    wr(ADDR_POWER, 8'h9f);
    rd(ADDR_POWER, 8'h93);
    $display("reset and port test done");
  endtask : t_reset
  task automatic t_power;
    wr(ADDR_POWER, 8'h91);
    for (n = 0; n < 6000 && bias !== POP_TOP; n++) @(posedge clk_i);
    settle(2);
    cmp_out(16'(n >= 4000), 16'h0001);
    cmp_reg({bias[7:1], low_power_o}, 8'hfe);
    $display("power up test done");
  endtask : t_power
  task automatic t_levels;
    wr(ADDR_LEFT_ANALOG, 8'hf6);
    wr(ADDR_RIGHT_ANALOG, 8'h05);
    wr(ADDR_LEFT_DIGITAL, 8'hc4);
    wr(ADDR_RIGHT_DIGITAL, 8'h12);
    settle(2);
    cmp_out(16'(hl.analog_db), 16'h000a);
    cmp_out(16'(hr.analog_db), 16'h0000);
    cmp_out(16'(hl.gain_eighths), 16'hfe20);
    cmp_out(16'(hr.gain_eighths), 16'h0090);
    wr(ADDR_RIGHT_DIGITAL, 8'h9f);
    settle(2);
    cmp_out(16'(hr.mute), 16'h0001);
    wr(ADDR_RIGHT_DIGITAL, 8'ha0);
    settle(2);
    cmp_out(16'(hr.mute), 16'h0000);
    wr(ADDR_MODE, 8'h08);
    settle(2);
    cmp_out(16'({hr.analog_db, hr.gain_eighths}), 16'h5620);
    $display("level test done");
  endtask : t_levels
  task automatic t_tone;
    wr(ADDR_TONE, 8'hd9);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MODE, {2'(c), 2'(c), 1'b0, 2'(c), 1'b0});
      settle(2);
      cmp_out({tone.low_level, tone.high_level, 2'h0, tone.low_corner,
        tone.high_corner, tone.emphasis},
        {8'hc9, 2'h0, 2'(c), 2'(c), 2'(c)});
    end
    double_speed_i = 1'b1;
    settle(3);
    cmp_out(16'({tone.high_level, tone.emphasis}), 16'h0000);
    double_speed_i = 1'b0;
    wr(ADDR_MODE, 8'h01);
    settle(2);
    cmp_out({tone.low_level, hl.gain_eighths, 1'b0}, 16'h0000);
    cmp_out(16'(hl.analog_db), 16'h000a);
    cmp_out(16'({tone.bypass, tone.automute, tone.high_active}), 16'h0004);
    wr(ADDR_MODE, 8'h00);
    $display("tone test done");
  endtask : t_tone
  task automatic t_attack;
    wr(ADDR_ATTACK, 8'h28);
    ticks = 0;
    steps = 0;
    limiter_enable = 1'b1;
    lim_clip = 1'b1;
    settle(41);
    lim_clip = 1'b0;
    settle(3);
    cmp_out(16'(steps), 16'((ticks * 40) / 32));
    limiter_enable = 1'b0;
    $display("attack test done");
  endtask : t_attack
  task automatic t_zero;
    wr(ADDR_POWER, 8'hb1);
    wr(ADDR_LEFT_DIGITAL, 8'hf6);
    settle(40);
    cmp_out(16'(hl.gain_eighths), 16'hfe20);
    zero_cross_i = 2'h1;
    settle(1);
    zero_cross_i = 2'h0;
    settle(2);
    cmp_out(16'(hl.gain_eighths), 16'hffb0);
    wr(ADDR_LEFT_DIGITAL, 8'h00);
    settle(2000);
    cmp_out(16'(hl.gain_eighths), 16'hffb0);
    settle(60);
    cmp_out(16'(hl.gain_eighths), 16'h0000);
    // ramped mode: gain walks one eighth of a dB per frame
    wr(ADDR_POWER, 8'hd1);
    wr(ADDR_LEFT_DIGITAL, 8'hf8);
    settle(20);
    cmp_out(16'(hl.gain_eighths < 11'sd0 && hl.gain_eighths > -11'sd8),
      16'h0001);
    settle(400);
    cmp_out(16'(hl.gain_eighths), 16'hffc0);
    wr(ADDR_POWER, 8'hb3);
    rd(ADDR_LEFT_ANALOG, 8'hf6);
    cmp_out(16'(low_power_o), 16'h0001);
    wr(ADDR_LEFT_ANALOG, 8'hf1);
    rd(ADDR_LEFT_ANALOG, 8'hf1);
    $display("zero cross and power down test done");
  endtask : t_zero
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    t_reset();
    t_power();
    t_levels();
    t_tone();
    t_attack();
    t_zero();
    complete_run();
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : tb_audio_dac_control_registers
